// ### sram_port_pkg.sv
// shared widths, reset values and access codes for the burst memory port
package sram_port_pkg;
  // address: upper bits plus the two burst bits
  localparam int ADDR_W = 18;
  localparam int BURST_W = 2;
  localparam int UPPER_W = ADDR_W - BURST_W;
  // four byte lanes of eight data bits and one parity bit
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = BYTE_W + 1;
  localparam int DATA_W = LANES * LANE_W;
  localparam int MEM_DEPTH = 1 << ADDR_W;
  // write queue in front of the storage array
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = ADDR_W + LANES + DATA_W;
  // burst counter step and reset values
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [LANES-1:0] BW_N_RST = 4'hf;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  localparam logic DRIVE_RST = 1'b0;
  // kind of access carried by a pipeline stage
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_READ = 3'b010,
    ACC_WRITE = 3'b100
  } access_e;
  localparam access_e ACC_RST = ACC_IDLE;
endpackage

// ### write_queue_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module write_queue_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  // depth must be a power of two so the pointers wrap on their own
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH]; // entry storage
  logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr; // next slot to fill
  logic [PTR_W-1:0] rd_ptr_ff, nxt_rd_ptr; // oldest entry
  logic [PTR_W:0] count_ff, nxt_count; // entries held
  logic push; // accepted on the filling side
  logic pop; // taken on the draining side

  // honest flags straight from the count
  assign in_ready_out = (count_ff != FULL_CNT);
  assign out_valid_out = (count_ff != '0);
  assign out_data_out = mem_ff[rd_ptr_ff];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // pointer and count update
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    if (push) begin
      nxt_wr_ptr = wr_ptr_ff + PTR_W'(1);
    end
    if (pop) begin
      nxt_rd_ptr = rd_ptr_ff + PTR_W'(1);
    end
    if (push && !pop) begin
      nxt_count = count_ff + (PTR_W+1)'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - (PTR_W+1)'(1);
    end
    if (!rstn_in) begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_count = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    wr_ptr_ff <= nxt_wr_ptr;
    rd_ptr_ff <= nxt_rd_ptr;
    count_ff <= nxt_count;
  end

  // storage needs no reset; only counted entries are ever read
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// ### burst_sram_port.sv
// pipelined burst static memory: input control, burst counter and array
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1: address inputs captured, select one location
// RL2: low lane select plus write strobe writes
// RL3: each lane select gates byte and parity
// RL4: write strobe sampled only while qualifier low
// RL5: controller drives strobe low to write
// RL6: advance high steps the burst counter
// RL7: advance low loads a new address
// RL8: controller loads fresh address after deselect
// RL9: clock edge recognised only with qualifier low
// RL10: high qualifier freezes state and outputs
// RL11: selected when one low, two high, three low
// RL12: strap high interleaved, low linear, fixed
// RL13: outputs off on write, deselect, resume
// RL14: burst advance changes only two low bits
module burst_sram_port
  import sram_port_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [sram_port_pkg::UPPER_W-1:0] addr_upper_in,
  input wire logic burst_lsb_address_0_in,
  input wire logic burst_lsb_address_1_in,
  input wire logic lane_a_write_select_n_in,
  input wire logic lane_b_write_select_n_in,
  input wire logic lane_c_write_select_n_in,
  input wire logic lane_d_write_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic advance_or_load_in,
  input wire logic clock_qualifier_n_in,
  input wire logic chip_select_one_n_in,
  input wire logic chip_select_two_in,
  input wire logic chip_select_three_n_in,
  input wire logic output_enable_n_in,
  input wire logic burst_order_in,
  input wire logic sleep_request_in,
  input wire logic [sram_port_pkg::BYTE_W-1:0] lane_a_data_io_in,
  output logic [sram_port_pkg::BYTE_W-1:0] lane_a_data_io_out,
  input wire logic lane_a_parity_io_in,
  output logic lane_a_parity_io_out,
  output logic lane_a_io_oe_out,
  input wire logic [sram_port_pkg::BYTE_W-1:0] lane_b_data_io_in,
  output logic [sram_port_pkg::BYTE_W-1:0] lane_b_data_io_out,
  input wire logic lane_b_parity_io_in,
  output logic lane_b_parity_io_out,
  output logic lane_b_io_oe_out,
  input wire logic [sram_port_pkg::BYTE_W-1:0] lane_c_data_io_in,
  output logic [sram_port_pkg::BYTE_W-1:0] lane_c_data_io_out,
  input wire logic lane_c_parity_io_in,
  output logic lane_c_parity_io_out,
  output logic lane_c_io_oe_out,
  input wire logic [sram_port_pkg::BYTE_W-1:0] lane_d_data_io_in,
  output logic [sram_port_pkg::BYTE_W-1:0] lane_d_data_io_out,
  input wire logic lane_d_parity_io_in,
  output logic lane_d_parity_io_out,
  output logic lane_d_io_oe_out,
  output logic write_queue_ready_out
);
  import sram_port_pkg::*;

  // how an access moves through the port:
  // - a recognised edge with advance low takes a new address, or
  //   deselects when the chip selects do not all agree
  // - a recognised edge with advance high steps the burst counter and
  //   repeats the kind of access that the burst started with
  // - the access then sits in stage one for one recognised cycle, where
  //   a read is looked up in the array
  // - in stage two a read has its word in the read register, and a write
  //   waits for its data, which the controller puts on the lanes now
  // - the output stage drives read data for one recognised cycle
  // a masked edge moves none of this, so a controller may stretch any
  // cycle by holding the qualifier high; the port stays selected then
  // limitation: the array has no reset, so a read of a location that was
  // never written returns unknown data

  // burst address generation
  logic [ADDR_W-1:0] base_ff, nxt_base; // address loaded at burst start
  logic [BURST_W-1:0] cnt_ff, nxt_cnt; // beats since the load
  access_e burst_op_ff, nxt_burst_op; // access kind the burst continues
  logic interleave_ff, nxt_interleave; // burst order strap, caught at reset
  // first pipeline stage: access just taken from the pins
  access_e s1_op_ff, nxt_s1_op;
  logic [ADDR_W-1:0] s1_addr_ff, nxt_s1_addr;
  logic [LANES-1:0] s1_bw_n_ff, nxt_s1_bw_n;
  // second stage: array read in flight, or write waiting for its data
  access_e s2_op_ff, nxt_s2_op;
  logic [ADDR_W-1:0] s2_addr_ff, nxt_s2_addr;
  logic [LANES-1:0] s2_bw_n_ff, nxt_s2_bw_n;
  // output register stage
  logic [DATA_W-1:0] dout_ff, nxt_dout; // word on the data pins
  logic drive_ff, nxt_drive; // pins may be driven this cycle
  // storage array and its read register
  logic [DATA_W-1:0] mem_ff [MEM_DEPTH];
  logic [DATA_W-1:0] rd_data_ff;
  // write queue between the pins and the array
  logic q_in_valid; // write data arriving from the pins
  logic q_out_valid; // a queued write is waiting
  logic q_in_ready_w; // queue has room for another write
  logic q_out_ready; // array accepts a queued write
  logic [FIFO_W-1:0] q_in_data;
  logic [FIFO_W-1:0] q_out_data;
  logic [ADDR_W-1:0] q_addr;
  logic [LANES-1:0] q_bw_n;
  logic [DATA_W-1:0] q_word;
  // pin groups packed lane a lowest, parity above its byte
  logic [DATA_W-1:0] din;
  logic [LANES-1:0] bw_n_pins;
  logic selected; // all three chip selects active
  logic edge_ok; // this clock edge is recognised
  access_e load_op; // access a load cycle would start

  assign din = {lane_d_parity_io_in, lane_d_data_io_in,
                lane_c_parity_io_in, lane_c_data_io_in,
                lane_b_parity_io_in, lane_b_data_io_in,
                lane_a_parity_io_in, lane_a_data_io_in}; // [RL3]
  assign bw_n_pins = {lane_d_write_select_n_in, lane_c_write_select_n_in,
                      lane_b_write_select_n_in, lane_a_write_select_n_in};
  // qualifier high masks the edge; nothing is deselected by it
  assign edge_ok = ~clock_qualifier_n_in; // [RL9] [RL10]
  assign selected = ~chip_select_one_n_in & chip_select_two_in
                    & ~chip_select_three_n_in; // [RL11]

  // low burst bits for a given start and beat count
  // interleaved order flips bits of the start, linear order counts up
  // and wraps inside the group of four, so the upper bits never move
  function automatic logic [BURST_W-1:0] burst_lsb(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] beat,
    input logic interleave
  );
    if (interleave) begin
      burst_lsb = start ^ beat; // [RL12]
    end else begin
      burst_lsb = start + beat; // [RL12]
    end
  endfunction

  // decode what a load cycle starts; strobe is only looked at on a
  // recognised edge because the caller gates with edge_ok
  always_comb begin
    if (!selected) begin
      load_op = ACC_IDLE; // deselect cycle
    end else if (!write_strobe_n_in) begin
      load_op = ACC_WRITE; // [RL4] [RL5]
    end else begin
      load_op = ACC_READ;
    end
  end

  // next values of the address generator and the pipeline
  always_comb begin
    nxt_base = base_ff;
    nxt_cnt = cnt_ff;
    nxt_burst_op = burst_op_ff;
    nxt_s1_op = s1_op_ff;
    nxt_s1_addr = s1_addr_ff;
    nxt_s1_bw_n = s1_bw_n_ff;
    nxt_s2_op = s2_op_ff;
    nxt_s2_addr = s2_addr_ff;
    nxt_s2_bw_n = s2_bw_n_ff;
    nxt_dout = dout_ff;
    nxt_drive = drive_ff;
    // the strap is taken while reset is held and then kept
    nxt_interleave = rstn_in ? interleave_ff : burst_order_in; // [RL12]
    if (edge_ok) begin
      if (advance_or_load_in) begin
        // continue the running burst; a deselect stays deselected
        nxt_cnt = cnt_ff + BURST_STEP; // [RL6]
        nxt_s1_op = burst_op_ff; // [RL6]
      end else begin
        nxt_base = {addr_upper_in, burst_lsb_address_1_in,
                    burst_lsb_address_0_in}; // [RL1] [RL7]
        nxt_cnt = BURST_CNT_RST; // [RL7]
        nxt_burst_op = load_op;
        nxt_s1_op = load_op; // [RL7]
      end
      // upper bits always come from the loaded base
      nxt_s1_addr = {nxt_base[ADDR_W-1:BURST_W],
                     burst_lsb(nxt_base[BURST_W-1:0], nxt_cnt,
                               interleave_ff)}; // [RL14] [RL1]
      nxt_s1_bw_n = bw_n_pins; // [RL2]
      nxt_s2_op = s1_op_ff;
      nxt_s2_addr = s1_addr_ff;
      nxt_s2_bw_n = s1_bw_n_ff;
      nxt_dout = rd_data_ff;
      // drive only read data; write data, deselect and the cycle after
      // it carry no read, so the pins float there whatever enable says
      // a write in stage one owns the next data cycle; a read that ends
      // in that same cycle is not driven, so the lanes never collide
      nxt_drive = (s2_op_ff == ACC_READ)
                  && (s1_op_ff != ACC_WRITE); // [RL13]
    end
    if (!rstn_in) begin
      nxt_base = ADDR_RST;
      nxt_cnt = BURST_CNT_RST;
      nxt_burst_op = ACC_RST;
      nxt_s1_op = ACC_RST;
      nxt_s1_addr = ADDR_RST;
      nxt_s1_bw_n = BW_N_RST;
      nxt_s2_op = ACC_RST;
      nxt_s2_addr = ADDR_RST;
      nxt_s2_bw_n = BW_N_RST;
      nxt_dout = DATA_RST;
      nxt_drive = DRIVE_RST;
    end
  end

  // register stage for everything computed above
  always_ff @(posedge clk_sys_in) begin
    base_ff <= nxt_base;
    cnt_ff <= nxt_cnt;
    burst_op_ff <= nxt_burst_op;
    interleave_ff <= nxt_interleave;
    s1_op_ff <= nxt_s1_op;
    s1_addr_ff <= nxt_s1_addr;
    s1_bw_n_ff <= nxt_s1_bw_n;
    s2_op_ff <= nxt_s2_op;
    s2_addr_ff <= nxt_s2_addr;
    s2_bw_n_ff <= nxt_s2_bw_n;
    dout_ff <= nxt_dout;
    drive_ff <= nxt_drive;
  end

  // write data is on the pins two edges after its address; it is queued
  // with the address and lane selects taken at the address edge
  assign q_in_valid = edge_ok & (s2_op_ff == ACC_WRITE) & rstn_in;
  assign q_in_data = {s2_addr_ff, s2_bw_n_ff, din};
  // sleep holds the drain while writes still enter, so the queue fills and the
  // controller sees ready fall; a masked edge holds both sides of the queue
  assign q_out_ready = edge_ok & ~sleep_request_in;
  assign {q_addr, q_bw_n, q_word} = q_out_data;
  // ready is straight from the queue count; a controller that writes
  // while it is low loses that word, which keeps the queue simple
  assign write_queue_ready_out = q_in_ready_w;

  // sixteen entries absorb a run of writes while sleep holds the drain;
  // the array side takes at most one word per edge
  write_queue_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_write_queue (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .in_valid_in(q_in_valid),
    .in_ready_out(q_in_ready_w),
    .in_data_in(q_in_data),
    .out_valid_out(q_out_valid),
    .out_ready_in(q_out_ready),
    .out_data_out(q_out_data)
  );

  // array: read for the first stage, lane writes drained from the queue;
  // a read does not look into the queue, so a read of a still-queued
  // write returns the older word
  always_ff @(posedge clk_sys_in) begin
    if (edge_ok && s1_op_ff == ACC_READ) begin
      rd_data_ff <= mem_ff[s1_addr_ff];
    end
    if (q_out_valid && q_out_ready) begin
      for (int i = 0; i < LANES; i++) begin
        if (!q_bw_n[i]) begin
          mem_ff[q_addr][i*LANE_W +: LANE_W] <=
            q_word[i*LANE_W +: LANE_W]; // [RL2] [RL3]
        end
      end
    end
  end

  // pin outputs; the enable input is asynchronous and only gates
  // one enable per lane covers both the byte and its parity bit
  // the data word itself always comes from the output register
  assign lane_a_io_oe_out = drive_ff & ~output_enable_n_in; // [RL13]
  assign lane_b_io_oe_out = drive_ff & ~output_enable_n_in; // [RL13]
  assign lane_c_io_oe_out = drive_ff & ~output_enable_n_in; // [RL13]
  assign lane_d_io_oe_out = drive_ff & ~output_enable_n_in; // [RL13]
  assign {lane_d_parity_io_out, lane_d_data_io_out,
          lane_c_parity_io_out, lane_c_data_io_out,
          lane_b_parity_io_out, lane_b_data_io_out,
          lane_a_parity_io_out, lane_a_data_io_out} = dout_ff; // [RL3]
endmodule
`default_nettype wire

// ### bus_ctrl_model.sv
// far-side model: settles the shared data lanes of the memory port
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  input wire logic clk_sys_in,
  input wire logic drive_in,
  input wire logic [35:0] word_in,
  input wire logic [3:0] dut_oe_in,
  input wire logic [35:0] dut_word_in,
  output logic [35:0] pin_out
);
  logic [35:0] last_ff; // last wire level, used to fake a floating bus
  // per lane: device drives, else controller, else junk that moves
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (dut_oe_in[k]) begin
        pin_out[k*9+:9] = dut_word_in[k*9+:9];
      end else if (drive_in) begin
        pin_out[k*9+:9] = word_in[k*9+:9];
      end else begin
        pin_out[k*9+:9] = ~last_ff[k*9+:9];
      end
    end
  end
  // inverting the last level keeps a stale value from passing a check
  always_ff @(posedge clk_sys_in) begin
    last_ff <= pin_out;
  end
endmodule
`default_nettype wire

// ### burst_sram_port_checker.sv
// pin-level assertions for the burst memory port
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port_checker (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic write_strobe_n_in,
  input wire logic advance_or_load_in,
  input wire logic clock_qualifier_n_in,
  input wire logic chip_select_one_n_in,
  input wire logic chip_select_two_in,
  input wire logic chip_select_three_n_in,
  input wire logic output_enable_n_in,
  input wire logic lane_a_io_oe_out,
  input wire logic lane_b_io_oe_out,
  input wire logic lane_c_io_oe_out,
  input wire logic lane_d_io_oe_out,
  input wire logic [sram_port_pkg::BYTE_W-1:0] lane_a_data_io_out
);
  import sram_port_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  logic sel, ld, st; // selected, recognised load, recognised step
  assign sel = !chip_select_one_n_in && chip_select_two_in &&
    !chip_select_three_n_in;
  assign ld = !clock_qualifier_n_in && !advance_or_load_in;
  assign st = !clock_qualifier_n_in && advance_or_load_in;
  // the pipeline only moves on recognised edges, so spans count those
  sequence rd_load; ld && sel && write_strobe_n_in; endsequence
  sequence wr_load; ld && sel && !write_strobe_n_in; endsequence
  sequence ds_load; ld && !sel; endsequence
  sequence two_edges; !clock_qualifier_n_in [*2]; endsequence
  a_read_drives: assert property (
    rd_load ##1 two_edges |=> lane_a_io_oe_out || output_enable_n_in)
    else $error("read load did not drive the lanes");
  a_desel_quiet: assert property (
    ds_load ##1 two_edges |=> !lane_a_io_oe_out)
    else $error("deselected load drove the lanes");
  a_write_quiet: assert property (
    wr_load ##1 !clock_qualifier_n_in |=> !lane_a_io_oe_out)
    else $error("lanes driven in write data cycle");
  a_step_read: assert property (
    rd_load ##1 st ##1 two_edges |=> lane_a_io_oe_out || output_enable_n_in)
    else $error("burst step of a read did not drive");
  a_strobe_ignored: assert property (
    rd_load ##1 (st && !write_strobe_n_in) ##1 two_edges
    |=> lane_a_io_oe_out || output_enable_n_in)
    else $error("strobe on a step turned a read round");
  a_step_desel: assert property (
    ds_load ##1 st ##1 two_edges |=> !lane_a_io_oe_out)
    else $error("step after deselect drove the lanes");
  a_mask_data: assert property (
    clock_qualifier_n_in |=> $stable(lane_a_data_io_out))
    else $error("read data moved on a masked edge");
  a_mask_oe: assert property (
    clock_qualifier_n_in ##1 $stable(output_enable_n_in)
    |-> $stable(lane_a_io_oe_out))
    else $error("lane enable moved on a masked edge");
  a_oe_gate: assert property (
    output_enable_n_in |-> !lane_a_io_oe_out)
    else $error("lanes driven with output drive off");
  a_lanes_match: assert property (
    {lane_b_io_oe_out, lane_c_io_oe_out, lane_d_io_oe_out}
    == {3{lane_a_io_oe_out}})
    else $error("lane enables disagree");
endmodule
bind burst_sram_port burst_sram_port_checker chk_u (.*);
`default_nettype wire

// ### testbench.sv
// self-checking bench for the burst memory port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sram_port_pkg::*;
  localparam logic [15:0] UP = 16'h5a3c; // fixed upper address bits
  logic clk_sys_in, rstn_in, burst_lsb_address_0_in, burst_lsb_address_1_in;
  logic lane_a_write_select_n_in, lane_b_write_select_n_in;
  logic lane_c_write_select_n_in, lane_d_write_select_n_in;
  logic write_strobe_n_in, advance_or_load_in, clock_qualifier_n_in;
  logic chip_select_one_n_in, chip_select_two_in, chip_select_three_n_in;
  logic output_enable_n_in, burst_order_in, sleep_request_in, drv;
  logic [UPPER_W-1:0] addr_upper_in;
  logic [BYTE_W-1:0] lane_a_data_io_in, lane_b_data_io_in;
  logic [BYTE_W-1:0] lane_c_data_io_in, lane_d_data_io_in;
  logic [BYTE_W-1:0] lane_a_data_io_out, lane_b_data_io_out;
  logic [BYTE_W-1:0] lane_c_data_io_out, lane_d_data_io_out;
  logic lane_a_parity_io_in, lane_b_parity_io_in;
  logic lane_c_parity_io_in, lane_d_parity_io_in;
  logic lane_a_parity_io_out, lane_b_parity_io_out;
  logic lane_c_parity_io_out, lane_d_parity_io_out;
  logic lane_a_io_oe_out, lane_b_io_oe_out, lane_c_io_oe_out;
  logic lane_d_io_oe_out, write_queue_ready_out;
  logic [DATA_W-1:0] pw, pin, dw, mem [4]; // mem: expected words
  logic [3:0] oe;
  int n_mismatch, n_tests;
  assign dw = {lane_d_parity_io_out, lane_d_data_io_out, lane_c_parity_io_out,
    lane_c_data_io_out, lane_b_parity_io_out, lane_b_data_io_out,
    lane_a_parity_io_out, lane_a_data_io_out};
  assign oe = {lane_d_io_oe_out, lane_c_io_oe_out, lane_b_io_oe_out,
    lane_a_io_oe_out};
  assign {lane_d_parity_io_in, lane_d_data_io_in, lane_c_parity_io_in,
    lane_c_data_io_in, lane_b_parity_io_in, lane_b_data_io_in,
    lane_a_parity_io_in, lane_a_data_io_in} = pin;
  burst_sram_port dut (.*);
  bus_ctrl_model far (.clk_sys_in, .drive_in(drv), .word_in(pw),
    .dut_oe_in(oe), .dut_word_in(dw), .pin_out(pin));
  // 25 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // low address bits of beat k, in the order caught at reset
  function automatic logic [1:0] ba(input logic [1:0] s, input int k);
    return burst_order_in ? s ^ 2'(k) : s + 2'(k);
  endfunction
  task automatic reset_dut(input logic ilv);
    rstn_in <= 1'b0;
    burst_order_in <= ilv;
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
  endtask
  // load plus three steps, then deselect; reads get two masked edges
  task automatic burst(input logic wr, input logic [1:0] s,
    input logic [3:0] bw, input logic [35:0] d);
    logic [1:0] a;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys_in);
      advance_or_load_in <= (i >= 1 && i <= 3);
      // strobe also low on steps, where it must be ignored
      write_strobe_n_in <= !((wr && i == 0) || (i >= 1 && i <= 3));
      chip_select_two_in <= (i <= 3); // later loads deselect
      {burst_lsb_address_1_in, burst_lsb_address_0_in} <= s;
      addr_upper_in <= UP;
      {lane_d_write_select_n_in, lane_c_write_select_n_in,
        lane_b_write_select_n_in, lane_a_write_select_n_in} <= ~bw;
      clock_qualifier_n_in <= !wr && (i == 6 || i == 7);
      drv <= wr && i >= 2 && i <= 5;
      pw <= d + 36'(i);
      if (wr && i >= 2 && i <= 5) begin
        a = ba(s, i - 2);
        for (int l = 0; l < 4; l++)
          if (bw[l]) mem[a][l*9+:9] = (d + 36'(i)) >> (l * 9);
      end
      #1;
      if (wr && i >= 2 && i <= 5) chk(36'(oe), 36'h0);
      if (wr) chk(36'(write_queue_ready_out), 36'h1);
      if (!wr && i >= 3) chk(36'(oe), 36'hf);
      if (!wr && i >= 3) chk(dw, mem[ba(s, (i > 6) ? 3 : i - 3)]);
    end
    repeat (8) @(posedge clk_sys_in);
  endtask
  // each chip select dropped alone, then a step, must leave the lanes off
  task automatic desel();
    for (int j = 0; j < 3; j++) begin
      @(posedge clk_sys_in);
      {chip_select_one_n_in, chip_select_two_in, chip_select_three_n_in} <=
        (j == 0) ? 3'b110 : (j == 1) ? 3'b000 : 3'b011;
      output_enable_n_in <= (j == 2);
      @(posedge clk_sys_in);
      advance_or_load_in <= 1'b1;
      repeat (3) begin
        @(posedge clk_sys_in);
        advance_or_load_in <= 1'b0;
        #1 chk(36'(oe), 36'h0);
      end
    end
    @(posedge clk_sys_in);
    {chip_select_one_n_in, chip_select_two_in, chip_select_three_n_in} <=
      3'b000;
    output_enable_n_in <= 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {drv, sleep_request_in, output_enable_n_in, burst_order_in} = '0;
    {advance_or_load_in, clock_qualifier_n_in, chip_select_one_n_in} = '0;
    {write_strobe_n_in, chip_select_two_in, chip_select_three_n_in} = 3'b100;
    {burst_lsb_address_1_in, burst_lsb_address_0_in, addr_upper_in} = '0;
    {lane_d_write_select_n_in, lane_c_write_select_n_in,
      lane_b_write_select_n_in, lane_a_write_select_n_in} = 4'hf;
    {rstn_in, pw} = '0;
    reset_dut(1'b0);
    burst(1'b1, 2'h0, 4'hf, 36'h0a1b2c3d4);
    burst(1'b1, 2'h1, 4'h2, 36'h9f8e7d6c5); // lane b only
    burst(1'b0, 2'h1, 4'hf, 36'h0);
    desel();
    reset_dut(1'b1);
    burst(1'b1, 2'h0, 4'hf, 36'h3c5a69788);
    burst(1'b0, 2'h1, 4'hf, 36'h0); // beats 1,0,3,2
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
